// File: design/ext_port_pkg.sv
// Constants for the external memory port pin control
package ext_port_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 24;
   localparam logic [17:0] ADDR_RST = 18'h00000;
   localparam logic [23:0] DATA_RST = 24'h000000;
   localparam int STROBE_W = 4;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10,
      ST_OFF = 2'b11
   } port_state_t;
endpackage

// File: design/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_reg <= '0;
         dout <= '0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// File: design/ext_mem_port_pin_control.sv
// External memory port pin drive control
`timescale 1ns/100ps
`default_nettype none
module ext_mem_port_pin_control
   import ext_port_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic bus_master,
   input wire logic standby,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic [AW-1:0] acc_addr,
   input wire logic [DW-1:0] acc_wdata,
   input wire logic [STROBE_W-1:0] acc_attr,
   output logic [DW-1:0] rd_data,
   output logic rd_valid,
   output logic [AW-1:0] addr_o,
   output logic addr_oe,
   input wire logic [DW-1:0] data_i,
   output logic [DW-1:0] data_o,
   output logic data_oe,
   output logic [DW-1:0] data_keep,
   output logic keep_en,
   output logic [STROBE_W-1:0] attr_row_strobe_o,
   output logic read_n_o,
   output logic write_n_o,
   output logic bus_busy_line_o,
   output logic col_strobe_n_o,
   output logic ctl_oe
);
   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   logic [DW-1:0] data_sync;
   sync2 #(.W(DW)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(data_i),
      .dout(data_sync)
   );

   // ----------------------------------------
   // Mastership and access state
   // ----------------------------------------
   port_state_t state_reg;
   logic own;
   assign own = bus_master && !standby;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= ST_OFF;
      end else if (!own) begin
         state_reg <= ST_OFF;
      end else if (acc_req) begin
         state_reg <= acc_write ? ST_WRITE : ST_READ;
      end else begin
         state_reg <= ST_IDLE;
      end
   end

   // Giving up the bus must silence the address, data and control drivers by the next edge; the keeper stays enabled
   sequence s_leave;
      !own;
   endsequence
   property p_standby_off;
      @(posedge ref_clk) disable iff (!rst_n) s_leave |=> !addr_oe && !data_oe && !ctl_oe;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("outputs driven without mastership");

   // ----------------------------------------
   // Address lines
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addr_o <= ADDR_RST;
         addr_oe <= 1'b0;
      end else begin
         addr_oe <= own;
         // Holding the value avoids needless toggling
         if (own && acc_req) begin
            addr_o <= acc_addr;
         end
      end
   end

   // Release edge left out: registers still see reset on that edge
   property p_addr_oe;
      @(posedge ref_clk) disable iff (!rst_n) rst_n && own |=> addr_oe;
   endproperty
   a_addr_oe: assert property (p_addr_oe) else $error("address not driven as master");
   property p_addr_val;
      @(posedge ref_clk) disable iff (!rst_n) rst_n && own && acc_req |=> addr_o == $past(acc_addr);
   endproperty
   a_addr_val: assert property (p_addr_val) else $error("address mismatch");
   property p_addr_hold;
      @(posedge ref_clk) disable iff (!rst_n) !(own && acc_req) |=> $stable(addr_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address changed when idle");

   // ----------------------------------------
   // Control strobes
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctl_oe <= 1'b0;
         read_n_o <= 1'b1;
         write_n_o <= 1'b1;
         bus_busy_line_o <= 1'b1;
         col_strobe_n_o <= 1'b1;
         attr_row_strobe_o <= '0;
      end else begin
         ctl_oe <= own;
         read_n_o <= !(own && acc_req && !acc_write);
         write_n_o <= !(own && acc_req && acc_write);
         bus_busy_line_o <= !own;
         col_strobe_n_o <= 1'b1;
         attr_row_strobe_o <= (own && acc_req) ? acc_attr : '0;
      end
   end

   // Strobes idle while released, so no stray access reaches memory
   property p_ctl_idle;
      @(posedge ref_clk) disable iff (!rst_n) !own |=>
         bus_busy_line_o && read_n_o && write_n_o && (attr_row_strobe_o == '0);
   endproperty
   a_ctl_idle: assert property (p_ctl_idle) else $error("strobe active without mastership");

   // ----------------------------------------
   // Data lines and keeper
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         data_o <= DATA_RST;
         data_oe <= 1'b0;
      end else begin
         data_oe <= own && acc_req && acc_write;
         if (own && acc_req && acc_write) begin
            data_o <= acc_wdata;
         end
      end
   end

   property p_write;
      @(posedge ref_clk) disable iff (!rst_n) rst_n && own && acc_req && acc_write |=>
         data_oe && data_o == $past(acc_wdata);
   endproperty
   a_write: assert property (p_write) else $error("write data not driven");
   property p_no_drive;
      @(posedge ref_clk) disable iff (!rst_n) !bus_master |=> !data_oe;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("data driven while not master");

   // Keeper only follows lines that were last driven by us
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         keep_en <= 1'b0;
         data_keep <= DATA_RST;
      end else if (data_oe) begin
         keep_en <= 1'b1;
         data_keep <= data_o;
      end else if (state_reg == ST_READ) begin
         keep_en <= 1'b0;
      end
   end

   property p_keep;
      @(posedge ref_clk) disable iff (!rst_n) data_oe ##1 !data_oe |-> keep_en && data_keep == $past(data_o);
   endproperty
   a_keep: assert property (p_keep) else $error("keeper lost last value");
   property p_keep_hold;
      @(posedge ref_clk) disable iff (!rst_n) rst_n && keep_en && !data_oe && (state_reg != ST_READ) |=>
         keep_en && $stable(data_keep);
   endproperty
   a_keep_hold: assert property (p_keep_hold) else $error("keeper value drifted");

   // ----------------------------------------
   // Read capture
   // ----------------------------------------
   // Pins reach data_sync two edges late, so capture waits out the synchroniser
   logic [1:0] rd_pipe_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_pipe_reg <= 2'h0;
      end else begin
         rd_pipe_reg <= {rd_pipe_reg[0], (state_reg == ST_READ) && own};
      end
   end

   // Reset data ignored; capture samples the pins only in the read strobe cycle, so memory need not hold read data after it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_data <= DATA_RST;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_pipe_reg[1] && own;
         if (rd_pipe_reg[1] && own) begin
            rd_data <= data_sync;
         end
      end
   end

   sequence s_rd_issue;
      rst_n && own && acc_req && !acc_write;
   endsequence
   sequence s_rd_owned;
      own [*3];
   endsequence
   property p_read;
      @(posedge ref_clk) disable iff (!rst_n) s_rd_issue ##1 s_rd_owned |=>
         rd_valid && rd_data == $past(data_sync);
   endproperty
   a_read: assert property (p_read) else $error("read data not captured");

   property p_reset;
      @(posedge ref_clk) !rst_n |=> !addr_oe && !data_oe && !rd_valid;
   endproperty
   a_reset: assert property (p_reset) else $error("drive during reset");
endmodule
`default_nettype wire

// File: dv/ext_mem_model.sv
// Behavioural static memory on the far side of the port
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
   input wire logic ref_clk,
   input wire logic [17:0] addr_o,
   input wire logic read_n_o,
   input wire logic write_n_o,
   input wire logic ctl_oe,
   input wire logic [23:0] data_o,
   input wire logic data_oe,
   input wire logic [23:0] data_keep,
   input wire logic keep_en,
   output logic [23:0] data_i
);
   logic [23:0] mem [0:15];
   logic [23:0] hold_reg;
   logic [23:0] last_reg = 24'h000000;
   logic [1:0] cnt_reg = 2'h0;
   always_ff @(posedge ref_clk) begin
      if (ctl_oe && !write_n_o && data_oe) mem[addr_o[3:0]] <= data_o;
      if (ctl_oe && !read_n_o) begin
         hold_reg <= mem[addr_o[3:0]];
         cnt_reg <= 2'h3;
      end else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
      last_reg <= data_i;
   end
   // Undriven lines toggle so a stale value never passes
   always_comb begin
      if (data_oe) data_i = data_o;
      else if (ctl_oe && !read_n_o) data_i = mem[addr_o[3:0]];
      else if (cnt_reg != 2'h0) data_i = hold_reg;
      else if (keep_en) data_i = data_keep;
      else data_i = ~last_reg;
   end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the port pin control
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ext_port_pkg::*;
   logic ref_clk = 0, rst_n = 0, bus_master = 1, standby = 0, acc_req = 0, acc_write = 0;
   logic [17:0] acc_addr = 18'h00000, addr_o;
   logic [23:0] acc_wdata = 24'h000000, rd_data, data_i, data_o, data_keep;
   logic [3:0] attr_row_strobe_o;
   logic rd_valid, addr_oe, data_oe, keep_en, read_n_o, write_n_o, ctl_oe, bus_busy_line_o, col_strobe_n_o;
   int fails = 0, checked = 0;
   logic [17:0] ra [4] = '{18'h3FFF1, 18'h00002, 18'h2AAA3, 18'h15554};
   logic [23:0] rd [4] = '{24'hFFFFFF, 24'h000001, 24'hA5A5A5, 24'h5A5A5A};
   always #50 ref_clk = ~ref_clk;
   ext_mem_port_pin_control ext_mem_port_pin_control_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .bus_master(bus_master), .standby(standby), .acc_req(acc_req), .acc_write(acc_write),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_attr(4'h1), .rd_data(rd_data),
      .rd_valid(rd_valid), .addr_o(addr_o), .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o),
      .data_oe(data_oe), .data_keep(data_keep), .keep_en(keep_en),
      .attr_row_strobe_o(attr_row_strobe_o), .read_n_o(read_n_o), .write_n_o(write_n_o),
      .bus_busy_line_o(bus_busy_line_o), .col_strobe_n_o(col_strobe_n_o), .ctl_oe(ctl_oe));
   ext_mem_model ext_mem_model_inst (.ref_clk(ref_clk), .addr_o(addr_o), .read_n_o(read_n_o),
      .write_n_o(write_n_o), .ctl_oe(ctl_oe), .data_o(data_o), .data_oe(data_oe),
      .data_keep(data_keep), .keep_en(keep_en), .data_i(data_i));
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [17:0] a, input logic [23:0] d, input logic refused);
      int n;
      @(posedge ref_clk);
      acc_req <= 1; acc_write <= w; acc_addr <= a; acc_wdata <= d;
      @(posedge ref_clk);
      acc_req <= 0;
      #1;
      n = 0;
      while (!(w ? write_n_o === 0 : rd_valid === 1) && n < 8) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("acc done", {23'h000000, n < 8}, {23'h000000, !refused});
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      fails++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1;
      for (int i = 0; i < 4; i++) begin
         acc(1, ra[i], rd[i], 0);
         check("addr_o", {6'h00, addr_o}, {6'h00, ra[i]});
         check("data_o", data_o, rd[i]);
         check("oe", {22'h000000, addr_oe, data_oe}, 24'h000003);
         check("busy col", {22'h000000, bus_busy_line_o, col_strobe_n_o}, 24'h000001);
         check("rd wr attr", {18'h00000, read_n_o, write_n_o, attr_row_strobe_o}, 24'h000021);
      end
      for (int i = 0; i < 4; i++) begin
         acc(0, ra[i], 24'h000000, 0);
         check("rd_data", rd_data, rd[i]);
      end
      $display("test rows done");
      acc(1, ra[2], rd[2], 0);
      @(posedge ref_clk);
      standby <= 1;
      repeat (3) @(posedge ref_clk);
      #1;
      check("standby oe", {21'h000000, addr_oe, data_oe, ctl_oe}, 24'h000000);
      check("keep_en", {23'h000000, keep_en}, 24'h000001);
      check("data_keep", data_keep, rd[2]);
      acc(1, ra[0], rd[0], 1);
      check("addr hold", {5'h00, addr_o, data_oe}, {5'h00, ra[2], 1'b0});
      $display("test standby done");
      @(posedge ref_clk);
      standby <= 0;
      bus_master <= 0;
      repeat (3) @(posedge ref_clk);
      #1;
      check("no master oe", {21'h000000, addr_oe, data_oe, ctl_oe}, 24'h000000);
      check("no master busy", {23'h000000, bus_busy_line_o}, 24'h000001);
      check("no master keep", data_keep, rd[2]);
      @(posedge ref_clk);
      bus_master <= 1;
      repeat (3) @(posedge ref_clk);
      #1;
      check("idle addr", {5'h00, addr_oe, addr_o}, {6'h01, ra[2]});
      $display("test ownership done");
      @(posedge ref_clk);
      rst_n <= 0;
      repeat (2) @(posedge ref_clk);
      #1;
      check("reset oe", {21'h000000, addr_oe, data_oe, ctl_oe}, 24'h000000);
      check("reset rd", {5'h00, rd_valid, addr_o}, {6'h00, ADDR_RST});
      @(posedge ref_clk);
      rst_n <= 1;
      acc(0, ra[1], 24'h000000, 0);
      check("rd after reset", rd_data, rd[1]);
      $display("test reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
